// File: logic/cph_params.svh
// Constants of the channel proxy command handler
// How it works
// - Proxy reached over path type 0x32
// - Accept no-op, sense, jump, identify
// - Identify returns FF, unit type, model
// - Decode setup command codes
// - Decode data command codes
// - Multi-byte fields travel big-endian
// - Unknown command ends with command reject
// - Length mismatch without suppression flags length
// - Suppressed check, short data: check condition
// - Suppressed check, long buffer: accept
// - Revision payload: number, length, options
// - Revisions 0,1 need zero option length
// - Bad revision combination gets command reject
// - Non-transitional device rejects revision 0
// - Non-transitional device rejects transport commands before a select
// - Revision select rejected while a revision is in force
// - Revision cleared when subchannel enabled
// - Transitional device assumes revision 0 implicitly
`ifndef CPH_PARAMS_SVH
`define CPH_PARAMS_SVH

// Basic channel command codes
`define CPH_CMD_NOP 8'h03
`define CPH_CMD_SENSE 8'h04
`define CPH_CMD_JUMP 8'h08
`define CPH_CMD_IDENT 8'hE4
// Transport setup command codes
`define CPH_CMD_VQ_SET 8'h13
`define CPH_CMD_DEV_RESET 8'h33
`define CPH_CMD_QIND_SET 8'h43
`define CPH_CMD_CIND_SET 8'h53
`define CPH_CMD_TIND_SET 8'h73
`define CPH_CMD_REV_SEL 8'h83
// Transport data command codes
`define CPH_CMD_FEAT_RD 8'h12
`define CPH_CMD_FEAT_WR 8'h11
`define CPH_CMD_CFG_RD 8'h22
`define CPH_CMD_CFG_WR 8'h21
`define CPH_CMD_STAT_WR 8'h31
`define CPH_CMD_QLIM_RD 8'h32

// Expected transfer lengths in bytes
`define CPH_LEN_ZERO 16'h0000
`define CPH_LEN_ONE 16'h0001
`define CPH_LEN_IDENT 16'h0100
`define CPH_LEN_SENSE 16'h0020
`define CPH_LEN_VQ_INFO 16'h0020
`define CPH_LEN_VQ_LEGACY 16'h0010
`define CPH_LEN_IND 16'h0008
`define CPH_LEN_THININT 16'h0019
`define CPH_LEN_FEAT 16'h0005
`define CPH_LEN_CFG 16'h0100
`define CPH_LEN_STATUS 16'h0001
`define CPH_LEN_QLIM 16'h0004
`define CPH_LEN_REV_HDR 16'h0004

// Identify answer layout
`define CPH_IDENT_RSVD 8'hFF
`define CPH_IDENT_FILL 8'h00
`define CPH_IDX_RSVD 16'h0000
`define CPH_IDX_CU_HI 16'h0001
`define CPH_IDX_CU_LO 16'h0002
`define CPH_IDX_MODEL 16'h0003

// Channel path type and revision numbers
`define CPH_CHPATH_TYPE 8'h32
`define CPH_REV_NUM_0 16'h0000
`define CPH_REV_NUM_1 16'h0001

`endif

// File: logic/cph_pkg.sv
// Types of the channel proxy command handler
`default_nettype none
package cph_pkg;

  // Ending status of a command
  typedef enum logic [1:0] {ST_OK, ST_CMD_REJECT, ST_INCORRECT_LEN, ST_CHECK_COND} cph_status_t;

  // Selected transport revision
  typedef enum logic [1:0] {REV_UNSET, REV_0, REV_1} cph_rev_t;

  // Command sequencer states
  typedef enum logic [1:0] {FSM_IDLE, FSM_WRITE, FSM_READ, FSM_DONE} cph_fsm_t;

  // All state of the command handler
  typedef struct packed {
    cph_fsm_t fsm;
    logic [7:0] code;
    logic [15:0] count;
    logic sli;
    logic [15:0] expected;
    logic [15:0] moved;
    logic [31:0] hdr;
    logic rej;
    cph_rev_t rev;
    logic en_d;
    logic cmd_ready;
    logic wr_ready;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic pl_valid;
    logic [7:0] pl_byte;
    logic [15:0] pl_wr_index;
    logic done_valid;
    cph_status_t done_status;
    logic commit;
    logic [7:0] commit_code;
    logic [7:0] chpath;
  } cph_regs_t;

endpackage : cph_pkg

`default_nettype wire

// File: logic/cph_len_if.sv
// Interface between sequencer and length checker
`timescale 1ns/100ps
`default_nettype none

interface cph_len_if;
  logic [15:0] count;           // Count given by the channel
  logic [15:0] expected;        // Count the command needs
  logic sli;                    // Length check suppressed
  cph_pkg::cph_status_t status; // Verdict on the lengths

  // Side that asks for a verdict
  modport req (output count, output expected, output sli, input status);
  // Side that judges the lengths
  modport chk (input count, input expected, input sli, output status);
endinterface : cph_len_if

`default_nettype wire

// File: logic/cph_len_check.sv
// Length verdict for a finished data transfer
`timescale 1ns/100ps
`default_nettype none

module cph_len_check (
  cph_len_if.chk lif // Lengths in, verdict out
);

  // Verdict from count, expected count and suppression flag
  always_comb begin
    lif.status = cph_pkg::ST_OK;
    if (!lif.sli) begin
      if (lif.count != lif.expected) begin
        lif.status = cph_pkg::ST_INCORRECT_LEN;
      end
    end else begin
      if (lif.count < lif.expected) begin
        lif.status = cph_pkg::ST_CHECK_COND;
      end
      // long buffer accepted: falls through as OK
    end
  end

endmodule : cph_len_check

`default_nettype wire

// File: logic/cph_cmd_handler.sv
// Channel proxy command decoder and revision sequencer
`timescale 1ns/100ps
`default_nettype none
`include "cph_params.svh"

module cph_cmd_handler #(
  parameter bit TRANSITIONAL = 1'b1,     // Offers legacy revision 0
  parameter logic [15:0] CU_TYPE = 16'hC0DE // Arbitrary control unit type value
) (
  input wire logic ref_clk,                       // System clock, 50 MHz
  input wire logic rst_n,                         // Synchronous reset, active low
  input wire logic subch_enable,                  // Subchannel enabled level
  input wire logic [7:0] dev_model,               // Attached device identifier
  input wire logic cmd_valid,                     // Command offered
  input wire logic [7:0] cmd_code,                // Command code
  input wire logic [15:0] cmd_count,              // Transfer count
  input wire logic cmd_sli,                       // Length check suppressed
  output logic cmd_ready,                         // Ready for a command
  input wire logic wr_valid,                      // Write data byte offered
  input wire logic [7:0] wr_byte,                 // Write data byte
  output logic wr_ready,                          // Write byte taken
  output logic rd_valid,                          // Read data byte present
  output logic [7:0] rd_byte,                     // Read data byte
  input wire logic rd_ready,                      // Read byte taken
  output logic [15:0] pl_index,                   // Next read byte index
  input wire logic [7:0] pl_rd_byte,              // Payload byte at pl_index
  output logic pl_valid,                          // Write byte forwarded
  output logic [7:0] pl_byte,                     // Forwarded write byte
  output logic [15:0] pl_wr_index,                // Index of forwarded byte
  output logic done_valid,                        // Command ended
  output cph_pkg::cph_status_t done_status,       // Ending status
  output logic commit,                            // Apply command effects
  output logic [7:0] commit_code,                 // Code of committed command
  output cph_pkg::cph_rev_t rev_state,            // Selected revision
  output logic [7:0] chpath_type                  // Channel path type
);

  cph_pkg::cph_regs_t r;   // Registered state
  cph_pkg::cph_regs_t n;   // Next state
  cph_len_if lif ();       // Link to length checker

  // Length checker
  cph_len_check u_len_check (
    .lif (lif.chk)
  );

  // Lengths handed to the checker
  assign lif.count = r.count;
  assign lif.expected = r.expected;
  assign lif.sli = r.sli;

  // Identify answer byte at a given index
  function automatic logic [7:0] ident_byte(
    input logic [15:0] idx,
    input logic [7:0] model
  );
    logic [7:0] b;
    b = `CPH_IDENT_FILL;
    if (idx == `CPH_IDX_RSVD) begin
      b = `CPH_IDENT_RSVD;
    end else if (idx == `CPH_IDX_CU_HI) begin
      b = CU_TYPE[15:8];
    end else if (idx == `CPH_IDX_CU_LO) begin
      b = CU_TYPE[7:0];
    end else if (idx == `CPH_IDX_MODEL) begin
      b = model;
    end
    return b;
  endfunction : ident_byte

  // Next-state logic
  always_comb begin
    logic [15:0] lim;       // Bytes to move this command
    logic [15:0] nxt_moved; // Moved count after this cycle
    logic [15:0] exp_len;   // Expected length of a new command
    logic known;            // Code is supported
    logic transport;        // Code is transport specific
    logic is_rd;            // Device sends data
    logic is_wr;            // Device takes data
    logic rej_now;          // Refused at decode
    logic [15:0] rev_num;   // Requested revision
    logic [15:0] opt_len;   // Requested option length
    logic rev_ok;           // Requested revision is offered
    cph_pkg::cph_rev_t eff_rev; // Revision in force for decode
    cph_pkg::cph_status_t fin;  // Final status
    // Never move more bytes than both sides allow
    lim = (r.count < r.expected) ? r.count : r.expected;
    nxt_moved = r.moved;
    exp_len = `CPH_LEN_ZERO;
    known = 1'b1;
    transport = 1'b0;
    is_rd = 1'b0;
    is_wr = 1'b0;
    rej_now = 1'b0;
    rev_num = r.hdr[31:16];
    opt_len = r.hdr[15:0];
    rev_ok = 1'b0;
    eff_rev = r.rev;
    fin = cph_pkg::ST_OK;

    // Defaults: pulses low, state held
    n = r;
    n.done_valid = 1'b0;
    n.commit = 1'b0;
    n.pl_valid = 1'b0;
    // Previous enable level, for edge detection
    n.en_d = subch_enable;
    n.chpath = `CPH_CHPATH_TYPE;

    case (r.fsm)
      // Wait for a command and decode it
      cph_pkg::FSM_IDLE: begin
        n.cmd_ready = 1'b1;
        if (cmd_valid && r.cmd_ready) begin
          n.cmd_ready = 1'b0;
          if (cmd_code == `CPH_CMD_NOP) begin
            exp_len = `CPH_LEN_ZERO;
          end else if (cmd_code == `CPH_CMD_SENSE) begin
            exp_len = `CPH_LEN_SENSE;
            is_rd = 1'b1;
          end else if (cmd_code == `CPH_CMD_JUMP) begin
            exp_len = `CPH_LEN_ZERO;
          end else if (cmd_code == `CPH_CMD_IDENT) begin
            exp_len = `CPH_LEN_IDENT;
            is_rd = 1'b1;
          end else if (cmd_code == `CPH_CMD_VQ_SET) begin
            transport = 1'b1;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_DEV_RESET) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_ZERO;
          end else if (cmd_code == `CPH_CMD_QIND_SET) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_IND;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_CIND_SET) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_IND;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_TIND_SET) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_THININT;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_REV_SEL) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_REV_HDR;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_FEAT_RD) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_FEAT;
            is_rd = 1'b1;
          end else if (cmd_code == `CPH_CMD_FEAT_WR) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_FEAT;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_CFG_RD) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_CFG;
            is_rd = 1'b1;
          end else if (cmd_code == `CPH_CMD_CFG_WR) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_CFG;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_STAT_WR) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_STATUS;
            is_wr = 1'b1;
          end else if (cmd_code == `CPH_CMD_QLIM_RD) begin
            transport = 1'b1;
            exp_len = `CPH_LEN_QLIM;
            is_rd = 1'b1;
          end else begin
            known = 1'b0;
          end

          if (!known) begin
            rej_now = 1'b1;
          end else if (transport && (cmd_code == `CPH_CMD_REV_SEL)) begin
            if (r.rev != cph_pkg::REV_UNSET) begin
              rej_now = 1'b1;
            end
          end else if (transport && (r.rev == cph_pkg::REV_UNSET)) begin
            if (TRANSITIONAL) begin
              eff_rev = cph_pkg::REV_0;
            end else begin
              rej_now = 1'b1;
            end
          end

          // Queue location block size follows the revision
          if (cmd_code == `CPH_CMD_VQ_SET) begin
            exp_len = (eff_rev == cph_pkg::REV_1) ? `CPH_LEN_VQ_INFO : `CPH_LEN_VQ_LEGACY;
          end

          // Fresh command: counters and header start empty
          n.code = cmd_code;
          n.count = cmd_count;
          n.sli = cmd_sli;
          n.expected = exp_len;
          n.moved = `CPH_LEN_ZERO;
          n.hdr = '0;
          n.rej = rej_now;
          n.wr_ready = 1'b0;
          if (rej_now) begin
            n.fsm = cph_pkg::FSM_DONE;
          end else begin
            n.rev = eff_rev;
            if (is_wr) begin
              n.fsm = cph_pkg::FSM_WRITE;
            end else if (is_rd) begin
              n.fsm = cph_pkg::FSM_READ;
            end else begin
              n.fsm = cph_pkg::FSM_DONE;
            end
          end
        end
      end

      // Take write bytes until the needed amount has arrived
      cph_pkg::FSM_WRITE: begin
        if (r.wr_ready && wr_valid) begin
          nxt_moved = r.moved + `CPH_LEN_ONE;
          // header shifts in, first byte highest
          n.hdr = {r.hdr[23:0], wr_byte};
          n.pl_valid = 1'b1;
          n.pl_byte = wr_byte;
          n.pl_wr_index = r.moved;
        end
        n.moved = nxt_moved;
        // Bytes past the needed amount stay with the channel
        if (nxt_moved < lim) begin
          n.wr_ready = 1'b1;
        end else begin
          n.wr_ready = 1'b0;
          n.fsm = cph_pkg::FSM_DONE;
        end
      end

      // Present read bytes one at a time
      cph_pkg::FSM_READ: begin
        if (r.rd_valid && rd_ready) begin
          n.rd_valid = 1'b0;
        end
        // Next byte follows at once when the slot is free
        if (!r.rd_valid || rd_ready) begin
          if (r.moved < lim) begin
            n.rd_valid = 1'b1;
            // Identify bytes are built here, all others come from payload logic
            if (r.code == `CPH_CMD_IDENT) begin
              n.rd_byte = ident_byte(r.moved, dev_model);
            end else begin
              n.rd_byte = pl_rd_byte;
            end
            n.moved = r.moved + `CPH_LEN_ONE;
          end else begin
            n.fsm = cph_pkg::FSM_DONE;
          end
        end
      end

      // Settle the ending status and apply the revision
      cph_pkg::FSM_DONE: begin
        if (rev_num == `CPH_REV_NUM_1) begin
          rev_ok = 1'b1;
        end else if (rev_num == `CPH_REV_NUM_0) begin
          rev_ok = TRANSITIONAL;
        end
        // Header checks of a select outrank the length verdict
        if (r.rej) begin
          fin = cph_pkg::ST_CMD_REJECT;
        end else if ((r.code == `CPH_CMD_REV_SEL) && (r.moved == `CPH_LEN_REV_HDR)) begin
          if ((opt_len != `CPH_LEN_ZERO) || !rev_ok) begin
            fin = cph_pkg::ST_CMD_REJECT;
          end else begin
            fin = lif.status;
          end
        end else begin
          fin = lif.status;
        end
        n.done_valid = 1'b1;
        n.done_status = fin;
        n.commit_code = r.code;
        n.commit = (fin == cph_pkg::ST_OK);
        if ((fin == cph_pkg::ST_OK) && (r.code == `CPH_CMD_REV_SEL)) begin
          n.rev = (rev_num == `CPH_REV_NUM_1) ? cph_pkg::REV_1 : cph_pkg::REV_0;
        end
        n.fsm = cph_pkg::FSM_IDLE;
      end

      default: begin
        n.fsm = cph_pkg::FSM_IDLE;
      end
    endcase

    // Kept last so a same-cycle select cannot outlive the enable
    // revision forgotten on enable
    if (subch_enable && !r.en_d) begin
      n.rev = cph_pkg::REV_UNSET;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign cmd_ready = r.cmd_ready;
  assign wr_ready = r.wr_ready;
  assign rd_valid = r.rd_valid;
  assign rd_byte = r.rd_byte;
  assign pl_index = r.moved;
  assign pl_valid = r.pl_valid;
  assign pl_byte = r.pl_byte;
  assign pl_wr_index = r.pl_wr_index;
  assign done_valid = r.done_valid;
  assign done_status = r.done_status;
  assign commit = r.commit;
  assign commit_code = r.commit_code;
  assign rev_state = r.rev;
  assign chpath_type = r.chpath;

endmodule : cph_cmd_handler

`default_nettype wire

// File: dv/cph_cmd_handler_properties.sv
// Concurrent checks on the command handler ports
`timescale 1ns/100ps
`default_nettype none
module cph_cmd_handler_properties #(
  parameter bit TRANSITIONAL = 1'b1 // Offers legacy revision 0
) (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic subch_enable, // Subchannel enabled
  input wire logic cmd_valid, // Command offered
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_count, // Transfer count
  input wire logic cmd_sli, // Length check off
  input wire logic cmd_ready, // Ready for command
  input wire logic wr_valid, // Write byte offered
  input wire logic [7:0] wr_byte, // Write byte
  input wire logic wr_ready, // Write byte taken
  input wire logic pl_valid, // Forwarded byte
  input wire logic [7:0] pl_byte, // Forwarded value
  input wire logic done_valid, // Command ended
  input wire cph_pkg::cph_status_t done_status, // Ending status
  input wire logic commit, // Apply effects
  input wire logic [7:0] commit_code, // Committed code
  input wire cph_pkg::cph_rev_t rev_state, // Selected revision
  input wire logic [7:0] chpath_type // Path type
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take; // Command taken this edge
  logic tport; // Transport command code other than revision select
  logic known; // Any decoded code
  // Decode helpers
  assign take = cmd_valid && cmd_ready;
  assign tport = cmd_code inside {8'h13, 8'h33, 8'h43, 8'h53, 8'h73, 8'h12, 8'h11, 8'h22,
    8'h21, 8'h31, 8'h32};
  assign known = tport || (cmd_code inside {8'h03, 8'h04, 8'h08, 8'hE4, 8'h83});
  a_path_type: assert property ($past(rst_n) |-> chpath_type == 8'h32)
    else $error("path type wrong");
  a_empty_ok: assert property (take && cmd_code inside {8'h03, 8'h08} &&
    cmd_count == 16'h0000 |-> ##2 done_valid && done_status == cph_pkg::ST_OK && commit)
    else $error("empty command did not end well");
  a_unknown_rejected: assert property (take && !known |-> ##2 done_valid &&
    done_status == cph_pkg::ST_CMD_REJECT && !commit) else $error("unknown code not rejected");
  a_len_flagged: assert property (take && cmd_code == 8'h03 && !cmd_sli &&
    cmd_count != 16'h0000 |-> ##2 done_valid && done_status == cph_pkg::ST_INCORRECT_LEN)
    else $error("length mismatch not flagged");
  a_long_accepted: assert property (take && cmd_code == 8'h03 && cmd_sli |->
    ##2 done_valid && done_status == cph_pkg::ST_OK) else $error("long buffer refused");
  a_reselect_rejected: assert property (take && cmd_code == 8'h83 &&
    rev_state != cph_pkg::REV_UNSET |-> ##2 done_valid && done_status == cph_pkg::ST_CMD_REJECT)
    else $error("second select not rejected");
  a_rev_no_switch: assert property ($past(rev_state) != cph_pkg::REV_UNSET &&
    rev_state != $past(rev_state) |-> rev_state == cph_pkg::REV_UNSET)
    else $error("revision switched");
  a_rev_cleared: assert property ($rose(subch_enable) |->
    ##[1:2] rev_state == cph_pkg::REV_UNSET) else $error("revision not cleared");
  a_rev_source: assert property ($past(rev_state) == cph_pkg::REV_UNSET &&
    rev_state == cph_pkg::REV_1 |-> commit_code == 8'h83 && done_status == cph_pkg::ST_OK)
    else $error("revision set without select");
  a_implied_rev0: assert property (TRANSITIONAL && take && tport &&
    rev_state == cph_pkg::REV_UNSET |-> ##[1:2] rev_state == cph_pkg::REV_0)
    else $error("legacy revision not assumed");
  a_write_forward: assert property (wr_valid && wr_ready |=>
    pl_valid && pl_byte == $past(wr_byte)) else $error("write byte not forwarded");
endmodule : cph_cmd_handler_properties
bind cph_cmd_handler cph_cmd_handler_properties #(.TRANSITIONAL(TRANSITIONAL)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .subch_enable(subch_enable), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_count(cmd_count), .cmd_sli(cmd_sli), .cmd_ready(cmd_ready),
  .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ready(wr_ready), .pl_valid(pl_valid),
  .pl_byte(pl_byte), .done_valid(done_valid), .done_status(done_status), .commit(commit),
  .commit_code(commit_code), .rev_state(rev_state), .chpath_type(chpath_type));
`default_nettype wire

// File: dv/cph_payload_model.sv
// Payload store answering read byte indices
`timescale 1ns/100ps
`default_nettype none
module cph_payload_model (
  input wire logic [15:0] pl_index, // Read byte index
  output logic [7:0] pl_rd_byte // Byte at that index
);
  // bytes by index
  // Distinct value per index shows any reordering
  assign pl_rd_byte = ~pl_index[7:0];
endmodule : cph_payload_model
`default_nettype wire

// File: dv/cph_cmd_handler_tb.sv
// Self-checking bench for the command handler
`timescale 1ns/100ps
`default_nettype none
module cph_cmd_handler_tb;
  localparam logic [15:0] CU = 16'h5A17; // Arbitrary unit type value
  localparam cph_pkg::cph_status_t OK = cph_pkg::ST_OK; // Good end
  localparam cph_pkg::cph_status_t RJ = cph_pkg::ST_CMD_REJECT; // Reject
  localparam cph_pkg::cph_status_t IL = cph_pkg::ST_INCORRECT_LEN; // Bad length
  localparam cph_pkg::cph_status_t CC = cph_pkg::ST_CHECK_COND; // Short data
  logic ref_clk = 1'b0; // Clock
  logic rst_n = 1'b0; // Reset
  logic subch_enable = 1'b1; // Subchannel on
  logic [7:0] dev_model = 8'h00; // Device id
  logic cmd_valid = 1'b0; // Command offered
  logic [7:0] cmd_code = 8'h00; // Code
  logic [15:0] cmd_count = 16'h0000; // Count
  logic cmd_sli = 1'b0; // Length check off
  logic wr_valid = 1'b0; // Write byte offered
  logic [7:0] wr_byte = 8'h00; // Write byte
  logic rd_ready = 1'b0; // Read byte taken
  logic cmd_ready, wr_ready, rd_valid, pl_valid, done_valid, commit; // Flags
  logic [7:0] rd_byte, pl_rd_byte, pl_byte, commit_code, chpath_type; // Bytes
  logic [15:0] pl_index, pl_wr_index; // Indices
  cph_pkg::cph_status_t done_status; // Ending status
  cph_pkg::cph_rev_t rev_state; // Revision
  logic [7:0] st_q[$]; // Expected statuses
  logic [7:0] by_q[$]; // Expected read bytes
  logic [23:0] wb_q[$]; // Expected forwarded index and byte
  logic [23:0] wnote; // Oldest forwarded note
  logic [7:0] bad[4] = '{8'h00, 8'h01, 8'h93, 8'hFF}; // Unknown codes
  logic [25:0] tbl[11] = '{{8'h13, 16'h0020, 2'd1}, {8'h33, 16'h0000, 2'd0},
    {8'h43, 16'h0008, 2'd1}, {8'h53, 16'h0008, 2'd1}, {8'h73, 16'h0019, 2'd1},
    {8'h12, 16'h0005, 2'd2}, {8'h11, 16'h0005, 2'd1}, {8'h22, 16'h0100, 2'd2},
    {8'h21, 16'h0100, 2'd1}, {8'h31, 16'h0001, 2'd1}, {8'h32, 16'h0004, 2'd2}}; // Code,len,dir
  int n_fail = 0; // Mismatches
  int checks_done = 0; // Comparisons
  int seed = 54; // Random seed
  // Clock of 20 ns
  always #10 ref_clk = ~ref_clk;
  // Random read stalls
  always @(negedge ref_clk) rd_ready <= 1'($random(seed));
  cph_cmd_handler #(.CU_TYPE(CU)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .subch_enable(subch_enable), .dev_model(dev_model), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_count(cmd_count), .cmd_sli(cmd_sli), .cmd_ready(cmd_ready),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .rd_ready(rd_ready), .pl_index(pl_index), .pl_rd_byte(pl_rd_byte),
    .pl_valid(pl_valid), .pl_byte(pl_byte), .pl_wr_index(pl_wr_index),
    .done_valid(done_valid), .done_status(done_status), .commit(commit),
    .commit_code(commit_code), .rev_state(rev_state), .chpath_type(chpath_type));
  cph_payload_model i_model (.pl_index(pl_index), .pl_rd_byte(pl_rd_byte));
  // Compare one value and count it
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  // Compare one index and count it
  task automatic cmp_idx(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_idx
  // Report counts and verdict
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Take the oldest note whenever a result shows
  always @(posedge ref_clk) begin
    if (rst_n && done_valid) begin
      cmp("done_status", st_q.size() ? st_q.pop_front() : 8'hxx, 8'(done_status));
    end
    if (rst_n && rd_valid && rd_ready) begin
      cmp("rd_byte", by_q.size() ? by_q.pop_front() : 8'hxx, rd_byte);
    end
    if (rst_n && pl_valid) begin
      wnote = wb_q.size() ? wb_q.pop_front() : 24'hxxxxxx;
      cmp("pl_byte", wnote[7:0], pl_byte);
      cmp_idx("pl_wr_index", wnote[23:8], pl_wr_index);
    end
  end
  // Revision level check once settled
  task automatic chk_rev(input cph_pkg::cph_rev_t e);
    repeat (2) @(negedge ref_clk);
    cmp("rev_state", 8'(e), 8'(rev_state));
  endtask : chk_rev
  // Offer one command, move its bytes and note results
  task automatic run(input logic [7:0] c, input logic [15:0] n, input logic s,
      input cph_pkg::cph_status_t st, input int nw, input int nr, input logic [31:0] h);
    int k;
    k = 0;
    st_q.push_back(8'(st));
    for (int i = 0; i < nr; i++) begin
      by_q.push_back(c != 8'hE4 ? ~i[7:0] : i == 0 ? 8'hFF : i == 1 ? CU[15:8] :
        i == 2 ? CU[7:0] : i == 3 ? dev_model : 8'h00);
    end
    cmd_code = c;
    cmd_count = n;
    cmd_sli = s;
    cmd_valid = 1'b1;
    while (!cmd_ready && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    // Strobe stays up between bytes, dropped once after the last
    for (int i = 0; i < nw; i++) begin
      wr_byte = c == 8'h83 ? h[31 - 8 * i -: 8] : 8'($random(seed));
      wr_valid = 1'b1;
      wb_q.push_back({i[15:0], wr_byte});
      while (!wr_ready && k < 2000) begin
        @(negedge ref_clk);
        k++;
      end
      @(negedge ref_clk);
    end
    wr_valid = 1'b0;
    while ((st_q.size() || by_q.size() || wb_q.size()) && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 2000) begin
      n_fail++;
      end_of_test();
    end
  endtask : run
  // Main sequence
  initial begin
    dev_model = 8'($random(seed));
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    chk_rev(cph_pkg::REV_UNSET);
    run(8'h03, 16'h0000, 1'b0, OK, 0, 0, 0);
    run(8'h08, 16'h0000, 1'b0, OK, 0, 0, 0);
    run(8'h04, 16'h0020, 1'b0, OK, 0, 32, 0);
    // bench keys on unit type, model random
    run(8'hE4, 16'h0100, 1'b0, OK, 0, 256, 0);
    run(8'h03, 16'h0003, 1'b0, IL, 0, 0, 0);
    run(8'h03, 16'h0009, 1'b1, OK, 0, 0, 0);
    foreach (bad[i]) run(bad[i], 16'h0000, 1'b0, RJ, 0, 0, 0);
    // highest revision first, then step down
    run(8'h83, 16'h0004, 1'b0, RJ, 4, 0, 32'h0002_0000);
    run(8'h83, 16'h0004, 1'b0, RJ, 4, 0, 32'h0001_0001);
    run(8'h83, 16'h0006, 1'b1, OK, 4, 0, 32'h0001_0000);
    chk_rev(cph_pkg::REV_1);
    run(8'h83, 16'h0004, 1'b0, RJ, 0, 0, 0);
    chk_rev(cph_pkg::REV_1);
    // exact lengths for every transport command except revision select
    foreach (tbl[i]) run(tbl[i][25:18], tbl[i][17:2], 1'b0, OK, tbl[i][0] ? tbl[i][17:2] : 0,
      tbl[i][1] ? tbl[i][17:2] : 0, 0);
    run(8'h31, 16'h0000, 1'b1, CC, 0, 0, 0);
    run(8'h12, 16'h0002, 1'b1, CC, 0, 2, 0);
    run(8'h31, 16'h0002, 1'b0, IL, 1, 0, 0);
    run(8'h11, 16'h0008, 1'b1, OK, 5, 0, 0);
    subch_enable = 1'b0;
    @(negedge ref_clk);
    subch_enable = 1'b1;
    chk_rev(cph_pkg::REV_UNSET);
    run(8'h33, 16'h0000, 1'b0, OK, 0, 0, 0);
    chk_rev(cph_pkg::REV_0);
    run(8'h83, 16'h0004, 1'b0, RJ, 0, 0, 0);
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    chk_rev(cph_pkg::REV_UNSET);
    run(8'h83, 16'h0004, 1'b0, OK, 4, 0, 32'h0000_0000);
    chk_rev(cph_pkg::REV_0);
    run(8'h13, 16'h0010, 1'b0, OK, 16, 0, 0);
    end_of_test();
  end
endmodule : cph_cmd_handler_tb
`default_nettype wire
